// ---- hdl/ipc_regs.sv ----
// Polarity configuration registers with serial frame receiver
`timescale 1ns/100ps
`include "ipc_params.svh"
module ipc_regs
(
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic [3:0] channel_select_code,
  input wire logic conv_start,
  input wire logic conv_busy,
  output ipc_pkg::ipc_conv_cfg_t conv_cfg,
  output logic data_invalid,
  output logic mode_write,
  output ipc_pkg::ipc_frame_t mode_word
);

  // ==========================================================
  // Link domain frame receiver
  logic [4:0] bit_cnt_reg;
  logic [14:0] shift_reg;
  ipc_pkg::ipc_frame_t word_hold_reg;
  logic tog_link_reg;

  always_ff @(posedge link_clk or posedge cs_n)
  begin
    if (cs_n)
      bit_cnt_reg <= 5'h00;
    else if (bit_cnt_reg != `IPC_FRAME_BITS)
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
  end

  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
      shift_reg <= 15'h0000;
    else
      shift_reg <= {shift_reg[13:0], din};
  end

  // Whole frame only; aborted or extra bits are dropped
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
      word_hold_reg <= 16'h0000;
    else if (!cs_n && bit_cnt_reg == `IPC_LAST_BIT)
      word_hold_reg <= {shift_reg, din};
  end

  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
      tog_link_reg <= 1'h0;
    else if (!cs_n && bit_cnt_reg == `IPC_LAST_BIT)
      tog_link_reg <= ~tog_link_reg;
  end

  // ==========================================================
  // Frame event crossing
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;
  logic tog_done_reg;
  logic frame_evt;
  ipc_pkg::ipc_frame_t word;
  logic cfg_evt;
  logic mode_evt;
  logic uni_evt;
  logic bip_evt;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tog_s1_reg <= 1'h0;
      tog_s2_reg <= 1'h0;
      tog_s3_reg <= 1'h0;
      tog_done_reg <= 1'h0;
    end
    else
    begin
      tog_s1_reg <= tog_link_reg;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
      tog_done_reg <= tog_s3_reg;
    end
  end

  // Word is stable long before the next frame ends
  // Toggle counts once second and third stages agree
  assign frame_evt = (tog_s2_reg == tog_s3_reg) &&
    (tog_s3_reg != tog_done_reg);
  assign word = word_hold_reg;
  assign cfg_evt = frame_evt && word.sel[4];
  assign mode_evt = frame_evt && !word.sel[4];
  assign uni_evt = frame_evt && word.sel == `IPC_UNI_CODE;
  assign bip_evt = frame_evt && word.sel == `IPC_BIP_CODE;

  // ==========================================================
  // Configuration registers
  logic [7:0] uni_pd_reg;
  logic com_ref_reg;
  logic [7:0] bip_reg;

  // Low two bits of the frame are not stored in these registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      uni_pd_reg <= `IPC_RST_PAIRS;
      com_ref_reg <= `IPC_RST_COM;
    end
    else if (uni_evt)
    begin
      uni_pd_reg <= word.pairs;
      com_ref_reg <= word.com;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bip_reg <= `IPC_RST_PAIRS;
    else if (bip_evt)
      bip_reg <= word.pairs;
  end

  // ==========================================================
  // Mode control hand-off and data validity
  logic invalid_next;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mode_write <= 1'h0;
    else
      mode_write <= mode_evt;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mode_word <= 16'h0000;
    else if (mode_evt)
      mode_word <= word;
  end

  // Set wins over clear
  always_comb
  begin
    invalid_next = data_invalid;
    if (mode_evt)
      invalid_next = 1'h0;
    if (cfg_evt && conv_busy)
      invalid_next = 1'h1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      data_invalid <= 1'h0;
    else
      data_invalid <= invalid_next;
  end

  // ==========================================================
  // Per pair resolution
  ipc_pkg::ipc_conv_mode_t pair_mode [8];
  logic [7:0] pair_twos;

  genvar p;
  generate
    for (p = 0; p < 8; p++)
    begin : g_pair
      assign pair_mode[p] =
        com_ref_reg ? ipc_pkg::conv_common_ref :
        uni_pd_reg[7 - p] ? ipc_pkg::conv_pseudo_pair :
        bip_reg[7 - p] ? ipc_pkg::conv_diff_pair :
        ipc_pkg::conv_single;
      assign pair_twos[p] = !com_ref_reg && !uni_pd_reg[7 - p] &&
        bip_reg[7 - p];
    end
  endgenerate

  // ==========================================================
  // Selected channel resolution, latched at conversion start
  logic [2:0] sel_pair;
  ipc_pkg::ipc_conv_mode_t sel_mode;
  ipc_pkg::ipc_conv_cfg_t cfg_next;

  assign sel_pair = channel_select_code[3:1];

  // Reference pin itself converts as a plain single channel
  always_comb
  begin
    sel_mode = pair_mode[sel_pair];
    if (sel_mode == ipc_pkg::conv_common_ref &&
        channel_select_code == `IPC_REF_CHAN)
      sel_mode = ipc_pkg::conv_single;
  end

  always_comb
  begin
    cfg_next.mode = sel_mode;
    cfg_next.pair = sel_pair;
    cfg_next.twos_comp = pair_twos[sel_pair];
    if (sel_mode == ipc_pkg::conv_pseudo_pair ||
        sel_mode == ipc_pkg::conv_diff_pair)
      cfg_next.channel = {sel_pair, 1'h0};
    else
      cfg_next.channel = channel_select_code;
  end

  // Registers written this cycle act from the next start
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      conv_cfg <= 10'h000;
    else if (conv_start)
      conv_cfg <= cfg_next;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic sel_pd;
  logic sel_bp;
  assign sel_pd = uni_pd_reg[3'h7 - sel_pair];
  assign sel_bp = bip_reg[3'h7 - sel_pair];

  sequence s_cfg_busy;
    cfg_evt && conv_busy;
  endsequence

  sequence s_mode_in;
    mode_evt ##1 mode_write;
  endsequence

  property p_uni_load;
    uni_evt |=> uni_pd_reg == $past(word.pairs) &&
      com_ref_reg == $past(word.com) && $stable(bip_reg);
  endproperty
  a_uni_load: assert property (p_uni_load)
    else $error("unipolar load wrong");

  property p_bip_load;
    bip_evt |=> bip_reg == $past(word.pairs) &&
      $stable(uni_pd_reg) && $stable(com_ref_reg);
  endproperty
  a_bip_load: assert property (p_bip_load)
    else $error("bipolar load wrong");

  property p_other_hold;
    frame_evt && word.sel != `IPC_UNI_CODE &&
      word.sel != `IPC_BIP_CODE |=>
      $stable(uni_pd_reg) && $stable(bip_reg) && $stable(com_ref_reg);
  endproperty
  a_other_hold: assert property (p_other_hold)
    else $error("foreign frame changed settings");

  property p_common;
    conv_start && com_ref_reg && channel_select_code != `IPC_REF_CHAN
      |=> conv_cfg.mode == ipc_pkg::conv_common_ref && !conv_cfg.twos_comp;
  endproperty
  a_common: assert property (p_common)
    else $error("common reference not taken");

  property p_diff;
    conv_start && !com_ref_reg && !sel_pd && sel_bp |=>
      conv_cfg.mode == ipc_pkg::conv_diff_pair && conv_cfg.twos_comp;
  endproperty
  a_diff: assert property (p_diff)
    else $error("differential pair wrong");

  property p_pseudo;
    conv_start && !com_ref_reg && sel_pd |=>
      conv_cfg.mode == ipc_pkg::conv_pseudo_pair && !conv_cfg.twos_comp;
  endproperty
  a_pseudo: assert property (p_pseudo)
    else $error("pseudo pair wrong");

  property p_single;
    conv_start && !com_ref_reg && !sel_pd && !sel_bp |=>
      conv_cfg.mode == ipc_pkg::conv_single && !conv_cfg.twos_comp &&
      conv_cfg.channel == $past(channel_select_code);
  endproperty
  a_single: assert property (p_single)
    else $error("single channel wrong");

  property p_odd_pair;
    conv_start && !com_ref_reg && (sel_pd || sel_bp) |=>
      conv_cfg.channel == {$past(sel_pair), 1'h0};
  endproperty
  a_odd_pair: assert property (p_odd_pair)
    else $error("pair member mismatch");

  property p_cfg_hold;
    !conv_start |=> $stable(conv_cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("settings changed mid conversion");

  property p_invalid_set;
    s_cfg_busy |=> data_invalid;
  endproperty
  a_invalid_set: assert property (p_invalid_set)
    else $error("invalid flag not set");

  property p_invalid_hold;
    data_invalid && !mode_evt |=> data_invalid;
  endproperty
  a_invalid_hold: assert property (p_invalid_hold)
    else $error("invalid flag dropped early");

  property p_invalid_clear;
    s_mode_in |-> !data_invalid;
  endproperty
  a_invalid_clear: assert property (p_invalid_clear)
    else $error("invalid flag not cleared");

endmodule

// ---- hdl/ipc_params.svh ----
// Constants of the input polarity configuration registers
// What this block does
// - Select code 10001 loads the unipolar register
// - Select code 10010 loads the bipolar register
// - Bits 10..3 are pseudo-differential pair bits
// - Clear pseudo bit with bipolar bit clear means two single-ended inputs
// - Bit 2 enables shared negative reference mode
// - Bipolar bits 10..3 select fully differential pairs
// - Clear bipolar bit gives unipolar straight binary
// - Bipolar only gives differential two's complement
// - Pseudo only gives pseudo-differential straight binary
// - Pseudo and bipolar both set: unipolar wins
// - Common reference forces referenced straight binary
// - Odd member selects same pair when differential
// - All clear converts single channel against ground
// - Config during conversion invalidates data until mode
`ifndef IPC_PARAMS_SVH
`define IPC_PARAMS_SVH
`define IPC_FRAME_BITS 5'h10
`define IPC_LAST_BIT 5'h0f
`define IPC_UNI_CODE 5'h11
`define IPC_BIP_CODE 5'h12
`define IPC_PAIR_MSB 10
`define IPC_PAIR_LSB 3
`define IPC_COM_BIT 2
`define IPC_CFG_FLAG_BIT 15
`define IPC_RST_PAIRS 8'h00
`define IPC_RST_COM 1'h0
`define IPC_REF_CHAN 4'hf
`endif

// ---- hdl/ipc_pkg.sv ----
// Types of the input polarity configuration registers
package ipc_pkg;
  typedef enum logic [1:0] {
    conv_single,
    conv_pseudo_pair,
    conv_diff_pair,
    conv_common_ref
  } ipc_conv_mode_t;

  typedef struct packed {
    logic [4:0] sel;
    logic [7:0] pairs;
    logic com;
    logic [1:0] unused;
  } ipc_frame_t;

  typedef struct packed {
    ipc_conv_mode_t mode;
    logic twos_comp;
    logic [3:0] channel;
    logic [2:0] pair;
  } ipc_conv_cfg_t;
endpackage

// ---- bench/ipc_host_model.sv ----
// Serial host model writing frames on the link
`timescale 1ns/100ps
module ipc_host_model
(
  output logic link_clk,
  output logic cs_n,
  output logic din
);
  // ==========================================
  // Idle link
  initial
  begin
    link_clk = 1'h0;
    cs_n = 1'h1;
    din = 1'h0;
  end
  // ==========================================
  // Frame of n bits, MSB first, clock still between frames
  task automatic send_frame(input logic [15:0] w, input int n);
    #7;
    cs_n = 1'h0;
    for (int i = 15; i > 15 - n; i--)
    begin
      din = w[i];
      #16 link_clk = 1'h1;
      #16 link_clk = 1'h0;
    end
    #16 cs_n = 1'h1;
    din = ~din;
  endtask
endmodule

// ---- bench/ipc_regs_bench.sv ----
// Testbench of the polarity configuration registers
`timescale 1ns/100ps
module ipc_regs_bench;
  logic clk, rst, link_clk, cs_n, din, conv_start, conv_busy;
  logic data_invalid, mode_write, com;
  logic [3:0] chan;
  logic [7:0] pu, pb;
  ipc_pkg::ipc_conv_cfg_t conv_cfg, last_exp;
  ipc_pkg::ipc_frame_t mode_word;
  int err_total, n_compared, cycles, mw_count;

  ipc_regs i_dut (.clk(clk), .rst(rst), .link_clk(link_clk), .cs_n(cs_n),
    .din(din), .channel_select_code(chan), .conv_start(conv_start),
    .conv_busy(conv_busy), .conv_cfg(conv_cfg),
    .data_invalid(data_invalid), .mode_write(mode_write),
    .mode_word(mode_word));
  ipc_host_model i_host (.link_clk(link_clk), .cs_n(cs_n), .din(din));

  // ==========================================
  // Clock, timeout, pulse catcher
  initial clk = 1'h0;
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    if (mode_write === 1'h1)
      mw_count++;
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      end_of_test();
    end
  end

  // ==========================================
  // Tasks
  task end_of_test;
    $display("errors %0d compared %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task check(input logic [15:0] got, input logic [15:0] exp, input string s);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask

  function ipc_pkg::ipc_conv_cfg_t expect_cfg(input logic [3:0] ch);
    ipc_pkg::ipc_conv_cfg_t e;
    logic [2:0] p;
    p = ch[3:1];
    e.pair = p;
    e.channel = ch;
    e.twos_comp = 1'h0;
    e.mode = ipc_pkg::conv_single;
    // Reference pin itself stays a plain single channel
    if (com)
    begin
      if (ch != 4'hf)
        e.mode = ipc_pkg::conv_common_ref;
    end
    else if (pu[3'h7 - p])
    begin
      e.mode = ipc_pkg::conv_pseudo_pair;
      e.channel = {p, 1'h0};
    end
    else if (pb[3'h7 - p])
    begin
      e.mode = ipc_pkg::conv_diff_pair;
      e.twos_comp = 1'h1;
      e.channel = {p, 1'h0};
    end
    return e;
  endfunction

  task sweep;
    for (int c = 0; c < 16; c++)
    begin
      @(negedge clk);
      chan = c[3:0];
      conv_start = 1'h1;
      @(negedge clk);
      conv_start = 1'h0;
      last_exp = expect_cfg(c[3:0]);
      check({6'h00, conv_cfg}, {6'h00, last_exp}, "setup");
    end
  endtask

  task cfg(input logic [15:0] w, input int n);
    i_host.send_frame(w, n);
    repeat (8) @(negedge clk);
    check({6'h00, conv_cfg}, {6'h00, last_exp}, "held setup");
    if (n == 16 && w[15:11] == 5'h11)
    begin
      pu = w[10:3];
      com = w[2];
    end
    if (n == 16 && w[15:11] == 5'h12)
      pb = w[10:3];
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    rst = 1'h1;
    chan = 4'h0;
    conv_start = 1'h0;
    conv_busy = 1'h0;
    pu = 8'h00;
    pb = 8'h00;
    com = 1'h0;
    last_exp = '0;
    err_total = 0;
    n_compared = 0;
    repeat (4) @(negedge clk);
    rst = 1'h0;
    check({15'h0000, data_invalid}, 16'h0000, "invalid at reset");
    sweep();
    cfg({5'h11, 8'ha5, 1'h0, 2'h3}, 16);
    cfg({5'h12, 8'h3c, 3'h7}, 16);
    sweep();
    cfg({5'h13, 8'hff, 3'h7}, 16);
    cfg({5'h11, 8'h00, 3'h7}, 15);
    check({15'h0000, data_invalid}, 16'h0000, "invalid idle");
    sweep();
    cfg({5'h11, 8'ha5, 1'h1, 2'h0}, 16);
    sweep();
    @(negedge clk);
    conv_busy = 1'h1;
    cfg({5'h12, 8'h00, 3'h0}, 16);
    check({15'h0000, data_invalid}, 16'h0001, "invalid set");
    conv_busy = 1'h0;
    i_host.send_frame(16'h1234, 16);
    repeat (8) @(negedge clk);
    check(mw_count[15:0], 16'h0001, "mode pulse");
    check(mode_word, 16'h1234, "mode word");
    check({15'h0000, data_invalid}, 16'h0000, "invalid clear");
    sweep();
    end_of_test();
  end
endmodule
